/* File: logic/err_route_pkg.sv */
// constants, register map and types shared by the error router and its watchdog
// assumes a 100 MHz system clock and a byte-addressed 32-bit register port
package err_route_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned FUSE_STAT_W = 8;
  localparam int unsigned CNT_W = 24;
  localparam int unsigned EVT_W = 6;
  localparam int unsigned CAUSE_W = 4;
  // register byte offsets
  localparam logic [7:0] OFS_WD_CTRL = 8'h00;
  localparam logic [7:0] OFS_WD_TIMEOUT = 8'h04;
  localparam logic [7:0] OFS_WD_WINDOW = 8'h08;
  localparam logic [7:0] OFS_WD_SERVICE = 8'h0c;
  localparam logic [7:0] OFS_WD_COUNT = 8'h10;
  localparam logic [7:0] OFS_PLL_CTRL_ONE = 8'h14;
  localparam logic [7:0] OFS_RESET_CAUSE = 8'h18;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h1c;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h20;
  // watchdog control fields
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_NMI_BIT = 1;
  // pll control field
  localparam int unsigned PLL_RST_EN_BIT = 0;
  // reset cause fields
  localparam int unsigned CAUSE_SUPPLY = 0;
  localparam int unsigned CAUSE_STC = 1;
  localparam int unsigned CAUSE_OSC_PLL = 2;
  localparam int unsigned CAUSE_WDOG = 3;
  // interrupt status fields
  localparam int unsigned EVT_WD_VIOL = 0;
  localparam int unsigned EVT_RESET = 1;
  localparam int unsigned EVT_CAN2_PAR = 2;
  localparam int unsigned EVT_LBIST = 3;
  localparam int unsigned EVT_FUSE = 4;
  localparam int unsigned EVT_CLOCK = 5;
  // reset values
  localparam logic [CNT_W-1:0] TIMEOUT_RST = 24'hffffff;
  localparam logic [CNT_W-1:0] WINDOW_RST = 24'hffffff;
  localparam logic [EVT_W-1:0] MASK_RST = 6'h00;
  typedef enum logic [0:0] {
    WD_OFF = 1'b0,
    WD_RUN = 1'b1
  } wd_state_t;
endpackage

/* File: logic/wd_link_if.sv */
// carrier between the error router and its windowed watchdog unit
// assumes both ends sit on the same system clock
`timescale 1ns/1ps
interface wd_link_if;
  logic start;
  logic service;
  logic [err_route_pkg::CNT_W-1:0] timeout;
  logic [err_route_pkg::CNT_W-1:0] window;
  logic [err_route_pkg::CNT_W-1:0] count;
  logic running;
  logic violation;
  modport ctl (output start, output service, output timeout, output window,
               input count, input running, input violation);
  modport unit (input start, input service, input timeout, input window,
                output count, output running, output violation);
endinterface

/* File: logic/windowed_watchdog_unit.sv */
// down-counting windowed watchdog: service allowed only while count <= window
// assumes start and service are one-cycle pulses from the router
`timescale 1ns/1ps
module windowed_watchdog_unit (
  input wire logic clk, // system clock
  input wire logic rst_n, // synchronised reset, active low
  wd_link_if.unit lnk // control and status toward the router
);
  err_route_pkg::wd_state_t state_ff;
  err_route_pkg::wd_state_t nxt_state;
  logic [err_route_pkg::CNT_W-1:0] count_ff;
  logic [err_route_pkg::CNT_W-1:0] nxt_count;
  logic viol_ff;
  logic nxt_viol;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_count = count_ff;
    nxt_viol = 1'b0;
    case (state_ff)
      err_route_pkg::WD_OFF:
      begin
        nxt_count = lnk.timeout;
        if (lnk.start)
        begin
          nxt_state = err_route_pkg::WD_RUN;
        end
      end
      err_route_pkg::WD_RUN:
      begin
        // no way back to off here: only reset leaves run
        if (lnk.service)
        begin
          nxt_count = lnk.timeout;
          nxt_viol = (count_ff > lnk.window); // early service
        end
        else if (count_ff == '0)
        begin
          nxt_count = lnk.timeout;
          nxt_viol = 1'b1; // expired unserviced
        end
        else
        begin
          nxt_count = count_ff - 1'b1;
        end
      end
      default:
      begin
        nxt_state = err_route_pkg::WD_OFF;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff <= err_route_pkg::WD_OFF;
      count_ff <= err_route_pkg::TIMEOUT_RST;
      viol_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      count_ff <= nxt_count;
      viol_ff <= nxt_viol;
    end
  end

  assign lnk.count = count_ff;
  assign lnk.running = (state_ff == err_route_pkg::WD_RUN);
  assign lnk.violation = viol_ff;
endmodule

/* File: logic/error_routing_and_windowed_watchdog.sv */
// error routing toward the error collector and reset logic, plus watchdog control
// assumes synchronous source inputs and a single-cycle strobe register port
//
// Design decisions made here: the strobed register port and the register addresses.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - second can controller parity error goes to collector group 1 channel 23
// - cpu self-test failure goes to collector group 1 channel 27
// - fuse autoload failure goes to group 3 channel 1, driving error pin
// - any fuse status bit set raises group 1 channel 40
// - fuse self-test failure raises group 1 channel 41
// - watchdog violation in nmi mode raises group 2 channel 24
// - supply out of range gives a reset, no collector channel
// - self-test controller cpu reset request resets and is logged as cause
// - oscillator fail or pll slip resets only when enabled; then logged
// - watchdog has a software-set service window
// - early, late or missing service is a violation
// - software picks reset or nmi on watchdog violation
// - watchdog starts disabled, counts only after software enables it
// - once enabled, disable attempts ignored until system reset
module error_routing_and_windowed_watchdog (
  input wire logic clk, // system clock, 100 MHz
  input wire logic rst_n, // system reset, active low, asynchronous
  input wire logic [7:0] addr, // register byte address
  input wire logic [31:0] wdata, // register write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [31:0] rdata, // read data, cycle after rd
  input wire logic can2_parity_err, // second_can_controller message memory parity
  input wire logic lbist_fail, // cpu logic self-test failure
  input wire logic fuse_autoload_err, // fuse_controller autoload error
  input wire logic [7:0] fuse_err_status, // fuse_controller error status bits
  input wire logic fuse_selftest_err, // fuse_controller self-test error
  input wire logic supply_out_of_range, // supply_monitor out of range
  input wire logic stc_cpu_reset_req, // cpu_selftest_controller reset request
  input wire logic osc_fail, // oscillator failure
  input wire logic pll_slip, // pll slip
  output logic err_g1_ch23, // error_collector group 1 channel 23
  output logic err_g1_ch27, // error_collector group 1 channel 27
  output logic err_g3_ch1, // error_collector group 3 channel 1
  output logic err_g1_ch40, // error_collector group 1 channel 40
  output logic err_g1_ch41, // error_collector group 1 channel 41
  output logic err_g2_ch24, // error_collector group 2 channel 24, nmi
  output logic sys_reset_req, // system reset request, registered, high one cycle after each cycle that has a reset cause
  output logic irq // level interrupt
);

  ////////////////////////////////////////////////////////////////////////////////
  // reset release

  logic rst_meta_ff;
  logic rst_sync_ff;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // decode helpers

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  function automatic logic [31:0] widen(input logic [23:0] v);
    widen = {8'h00, v};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // watchdog unit

  wd_link_if wd_lnk ();

  windowed_watchdog_unit u_wd (
    .clk(clk),
    .rst_n(rst_sync_ff),
    .lnk(wd_lnk)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // software configuration

  logic nmi_sel_ff;
  logic nxt_nmi_sel;
  logic [23:0] timeout_ff;
  logic [23:0] nxt_timeout;
  logic [23:0] window_ff;
  logic [23:0] nxt_window;
  logic pll_rst_en_ff;
  logic nxt_pll_rst_en;
  logic [5:0] mask_ff;
  logic [5:0] nxt_mask;
  logic start_req;
  logic service_req;
  logic cfg_open;

  always_comb
  begin
    nxt_nmi_sel = nmi_sel_ff;
    nxt_timeout = timeout_ff;
    nxt_window = window_ff;
    nxt_pll_rst_en = pll_rst_en_ff;
    nxt_mask = mask_ff;
    cfg_open = !wd_lnk.running;
    start_req = 1'b0;
    service_req = 1'b0;
    if (wr)
    begin
      if (hit(addr, err_route_pkg::OFS_WD_CTRL))
      begin
        // a zero in the enable bit is simply ignored
        start_req = wdata[err_route_pkg::CTRL_EN_BIT] && cfg_open;
        if (cfg_open)
        begin
          nxt_nmi_sel = wdata[err_route_pkg::CTRL_NMI_BIT];
        end
      end
      if (hit(addr, err_route_pkg::OFS_WD_TIMEOUT) && cfg_open)
      begin
        nxt_timeout = wdata[23:0];
      end
      if (hit(addr, err_route_pkg::OFS_WD_WINDOW) && cfg_open)
      begin
        nxt_window = wdata[23:0];
      end
      if (hit(addr, err_route_pkg::OFS_WD_SERVICE))
      begin
        service_req = wd_lnk.running;
      end
      if (hit(addr, err_route_pkg::OFS_PLL_CTRL_ONE))
      begin
        nxt_pll_rst_en = wdata[err_route_pkg::PLL_RST_EN_BIT];
      end
      if (hit(addr, err_route_pkg::OFS_IRQ_MASK))
      begin
        nxt_mask = wdata[5:0];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      nmi_sel_ff <= 1'b0;
      timeout_ff <= err_route_pkg::TIMEOUT_RST;
      window_ff <= err_route_pkg::WINDOW_RST;
      pll_rst_en_ff <= 1'b0;
      mask_ff <= err_route_pkg::MASK_RST;
    end
    else
    begin
      nmi_sel_ff <= nxt_nmi_sel;
      timeout_ff <= nxt_timeout;
      window_ff <= nxt_window;
      pll_rst_en_ff <= nxt_pll_rst_en;
      mask_ff <= nxt_mask;
    end
  end

  assign wd_lnk.start = start_req;
  assign wd_lnk.service = service_req;
  assign wd_lnk.timeout = timeout_ff;
  assign wd_lnk.window = window_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // error channels and reset routing

  logic g1_ch23_ff;
  logic g1_ch27_ff;
  logic g3_ch1_ff;
  logic g1_ch40_ff;
  logic g1_ch41_ff;
  logic g2_ch24_ff;
  logic reset_ff;
  logic nxt_g2_ch24;
  logic nxt_reset;
  logic [3:0] cause_set;
  logic wd_reset;

  always_comb
  begin
    // the nmi choice only matters at the moment a violation fires
    nxt_g2_ch24 = wd_lnk.violation && nmi_sel_ff;
    wd_reset = wd_lnk.violation && !nmi_sel_ff;
    cause_set = 4'h0;
    cause_set[err_route_pkg::CAUSE_SUPPLY] = supply_out_of_range;
    cause_set[err_route_pkg::CAUSE_STC] = stc_cpu_reset_req;
    cause_set[err_route_pkg::CAUSE_OSC_PLL] = (osc_fail || pll_slip) && pll_rst_en_ff;
    cause_set[err_route_pkg::CAUSE_WDOG] = wd_reset;
    nxt_reset = |cause_set;
  end

  always_ff @(posedge clk or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      g1_ch23_ff <= 1'b0;
      g1_ch27_ff <= 1'b0;
      g3_ch1_ff <= 1'b0;
      g1_ch40_ff <= 1'b0;
      g1_ch41_ff <= 1'b0;
      g2_ch24_ff <= 1'b0;
      reset_ff <= 1'b0;
    end
    else
    begin
      g1_ch23_ff <= can2_parity_err;
      g1_ch27_ff <= lbist_fail;
      g3_ch1_ff <= fuse_autoload_err;
      g1_ch40_ff <= |fuse_err_status;
      g1_ch41_ff <= fuse_selftest_err;
      g2_ch24_ff <= nxt_g2_ch24;
      reset_ff <= nxt_reset;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // reset cause log, write one to clear; a new cause beats the clear

  logic [3:0] cause_ff;
  logic [3:0] nxt_cause;
  logic [3:0] cause_clr;

  always_comb
  begin
    cause_clr = 4'h0;
    if (wr && hit(addr, err_route_pkg::OFS_RESET_CAUSE))
    begin
      cause_clr = wdata[3:0];
    end
    nxt_cause = (cause_ff & ~cause_clr) | cause_set;
  end

  always_ff @(posedge clk or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      cause_ff <= 4'h0;
    end
    else
    begin
      cause_ff <= nxt_cause;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // interrupt status, cleared by reading it; set wins over the read

  logic [5:0] irq_st_ff;
  logic [5:0] nxt_irq_st;
  logic [5:0] evt_set;
  logic irq_ff;
  logic nxt_irq;
  logic st_read;

  always_comb
  begin
    evt_set = 6'h00;
    evt_set[err_route_pkg::EVT_WD_VIOL] = wd_lnk.violation;
    evt_set[err_route_pkg::EVT_RESET] = nxt_reset;
    evt_set[err_route_pkg::EVT_CAN2_PAR] = can2_parity_err;
    evt_set[err_route_pkg::EVT_LBIST] = lbist_fail;
    evt_set[err_route_pkg::EVT_FUSE] = fuse_autoload_err || fuse_selftest_err;
    evt_set[err_route_pkg::EVT_CLOCK] = osc_fail || pll_slip;
    st_read = rd && hit(addr, err_route_pkg::OFS_IRQ_STATUS);
    nxt_irq_st = (st_read ? 6'h00 : irq_st_ff) | evt_set;
    nxt_irq = |(nxt_irq_st & mask_ff);
  end

  always_ff @(posedge clk or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      irq_st_ff <= 6'h00;
      irq_ff <= 1'b0;
    end
    else
    begin
      irq_st_ff <= nxt_irq_st;
      irq_ff <= nxt_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read port; unmapped addresses read as zero

  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;

  always_comb
  begin
    nxt_rdata = 32'h0000_0000;
    if (rd)
    begin
      case (addr)
        err_route_pkg::OFS_WD_CTRL:
        begin
          nxt_rdata[err_route_pkg::CTRL_EN_BIT] = wd_lnk.running;
          nxt_rdata[err_route_pkg::CTRL_NMI_BIT] = nmi_sel_ff;
        end
        err_route_pkg::OFS_WD_TIMEOUT:
        begin
          nxt_rdata = widen(timeout_ff);
        end
        err_route_pkg::OFS_WD_WINDOW:
        begin
          nxt_rdata = widen(window_ff);
        end
        err_route_pkg::OFS_WD_COUNT:
        begin
          nxt_rdata = widen(wd_lnk.count);
        end
        err_route_pkg::OFS_PLL_CTRL_ONE:
        begin
          nxt_rdata[err_route_pkg::PLL_RST_EN_BIT] = pll_rst_en_ff;
        end
        err_route_pkg::OFS_RESET_CAUSE:
        begin
          nxt_rdata[3:0] = cause_ff;
        end
        err_route_pkg::OFS_IRQ_STATUS:
        begin
          nxt_rdata[5:0] = irq_st_ff;
        end
        err_route_pkg::OFS_IRQ_MASK:
        begin
          nxt_rdata[5:0] = mask_ff;
        end
        default:
        begin
          nxt_rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      rdata_ff <= 32'h0000_0000;
    end
    else
    begin
      rdata_ff <= nxt_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  assign rdata = rdata_ff;
  assign err_g1_ch23 = g1_ch23_ff;
  assign err_g1_ch27 = g1_ch27_ff;
  assign err_g3_ch1 = g3_ch1_ff;
  assign err_g1_ch40 = g1_ch40_ff;
  assign err_g1_ch41 = g1_ch41_ff;
  assign err_g2_ch24 = g2_ch24_ff;
  assign sys_reset_req = reset_ff;
  assign irq = irq_ff;
endmodule

/* File: verif/err_route_checker_properties.sv */
// checker for the error router: channel routing, reset causes, nmi gating
// assumes it is bound onto the top module and sees only its ports
`timescale 1ns/1ps
module err_route_checker (
  input wire logic clk, // system clock
  input wire logic rst_n, // reset, active low
  input wire logic [7:0] addr, // register address
  input wire logic [31:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic can2_parity_err, // parity source
  input wire logic lbist_fail, // self-test source
  input wire logic fuse_autoload_err, // autoload source
  input wire logic [7:0] fuse_err_status, // fuse status source
  input wire logic fuse_selftest_err, // fuse self-test source
  input wire logic supply_out_of_range, // supply source
  input wire logic stc_cpu_reset_req, // stc source
  input wire logic osc_fail, // oscillator source
  input wire logic pll_slip, // pll source
  input wire logic err_g1_ch23, // channel out
  input wire logic err_g1_ch27, // channel out
  input wire logic err_g3_ch1, // channel out
  input wire logic err_g1_ch40, // channel out
  input wire logic err_g1_ch41, // channel out
  input wire logic err_g2_ch24, // nmi channel out
  input wire logic sys_reset_req // reset request out
);
  logic [1:0] up_ff;
  logic armed;
  logic en_ff;
  logic nmi_ff;
  logic pll_en_ff;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // mirror of control bits, enable and nmi lock-once, pll enable always writable; up_ff skips the two-flop reset release
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      up_ff <= 2'h0;
      en_ff <= 1'b0;
      nmi_ff <= 1'b0;
      pll_en_ff <= 1'b0;
    end
    else
    begin
      if (up_ff != 2'h3) up_ff <= up_ff + 2'h1;
      if (wr && addr == err_route_pkg::OFS_WD_CTRL && !en_ff) nmi_ff <= wdata[1];
      if (wr && addr == err_route_pkg::OFS_WD_CTRL && wdata[0]) en_ff <= 1'b1;
      if (wr && addr == err_route_pkg::OFS_PLL_CTRL_ONE) pll_en_ff <= wdata[0];
    end
  end
  assign armed = (up_ff == 2'h3);
  ////////////////////////////////////////////////////////////////////////////////
  a_can2_route: assert property (armed |-> err_g1_ch23 == $past(can2_parity_err))
    else $error("parity error not on group 1 channel 23");
  a_lbist_route: assert property (armed |-> err_g1_ch27 == $past(lbist_fail))
    else $error("self-test failure not on group 1 channel 27");
  a_autoload_route: assert property (armed |-> err_g3_ch1 == $past(fuse_autoload_err))
    else $error("autoload error not on group 3 channel 1");
  a_fuse_any_bit: assert property (armed |-> err_g1_ch40 == |$past(fuse_err_status))
    else $error("fuse status not on group 1 channel 40");
  a_fuse_selftest: assert property (armed |-> err_g1_ch41 == $past(fuse_selftest_err))
    else $error("fuse self-test not on group 1 channel 41");
  a_supply_reset: assert property (supply_out_of_range && armed |=> sys_reset_req)
    else $error("supply fault gave no reset");
  a_stc_reset: assert property (stc_cpu_reset_req && armed |=> sys_reset_req)
    else $error("stc request gave no reset");
  a_clock_gate: assert property ((osc_fail || pll_slip) && pll_en_ff && armed
    |=> sys_reset_req)
    else $error("enabled clock fault gave no reset");
  a_reset_cause_only: assert property (sys_reset_req && armed |->
    $past(supply_out_of_range || stc_cpu_reset_req || ((osc_fail || pll_slip) && pll_en_ff))
    || (en_ff && !nmi_ff))
    else $error("reset request without a cause");
  a_nmi_needs_mode: assert property (err_g2_ch24 |-> en_ff && nmi_ff)
    else $error("nmi channel while watchdog off or in reset mode");
  cover property (err_g2_ch24);
  cover property (sys_reset_req && en_ff);
  cover property (err_g1_ch40);
endmodule

bind error_routing_and_windowed_watchdog err_route_checker i_chk (.clk(clk), .rst_n(rst_n),
  .addr(addr), .wdata(wdata), .wr(wr), .can2_parity_err(can2_parity_err),
  .lbist_fail(lbist_fail), .fuse_autoload_err(fuse_autoload_err),
  .fuse_err_status(fuse_err_status), .fuse_selftest_err(fuse_selftest_err),
  .supply_out_of_range(supply_out_of_range), .stc_cpu_reset_req(stc_cpu_reset_req),
  .osc_fail(osc_fail), .pll_slip(pll_slip), .err_g1_ch23(err_g1_ch23),
  .err_g1_ch27(err_g1_ch27), .err_g3_ch1(err_g3_ch1), .err_g1_ch40(err_g1_ch40),
  .err_g1_ch41(err_g1_ch41), .err_g2_ch24(err_g2_ch24), .sys_reset_req(sys_reset_req));

/* File: verif/err_collector_model.sv */
// model of the collector and reset side: counts nmi pulses and reset requests
// assumes one system clock; counts never clear so they survive a reset
`timescale 1ns/1ps
module err_collector_model (
  input wire logic clk, // system clock
  input wire logic nmi, // group 2 channel 24
  input wire logic reset_req, // toward reset logic
  output int nmi_seen, // nmi pulses taken
  output int rst_seen // reset requests taken
);
  initial
  begin
    nmi_seen = 0;
    rst_seen = 0;
  end
  always @(posedge clk)
  begin
    if (nmi === 1'b1) nmi_seen <= nmi_seen + 1;
    if (reset_req === 1'b1) rst_seen <= rst_seen + 1;
  end
endmodule

/* File: verif/tb.sv */
// bench for the error router and watchdog: routing, reset causes, both watchdog modes
// assumes the design files, checker and collector model are compiled before it
`timescale 1ns/1ps
module tb;
  logic clk;
  logic rst_n;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic wr, rd, can2, lbist, fal, fst, sup, cpu_selftest_controller, osc, pll;
  logic [7:0] fes;
  logic [31:0] rdata;
  wire [4:0] chan;
  logic ch24, rreq, irq;
  int nmi_seen, rst_seen;
  int bad_count = 0;
  int checked = 0;
  int cyc = 0;
  error_routing_and_windowed_watchdog i_dut (.clk(clk), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .can2_parity_err(can2),
    .lbist_fail(lbist), .fuse_autoload_err(fal), .fuse_err_status(fes),
    .fuse_selftest_err(fst), .supply_out_of_range(sup), .stc_cpu_reset_req(cpu_selftest_controller),
    .osc_fail(osc), .pll_slip(pll), .err_g1_ch23(chan[4]), .err_g1_ch27(chan[3]),
    .err_g3_ch1(chan[2]), .err_g1_ch40(chan[1]), .err_g1_ch41(chan[0]),
    .err_g2_ch24(ch24), .sys_reset_req(rreq), .irq(irq));
  err_collector_model i_col (.clk(clk), .nmi(ch24), .reset_req(rreq), .nmi_seen(nmi_seen),
    .rst_seen(rst_seen));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    if (bad_count == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      bad_count++;
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
  task automatic t_routes();
    logic [4:0] exp_tab [6] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h02, 5'h01};
    for (int i = 0; i < 6; i++)
    begin
      @(posedge clk);
      can2 <= (i == 0);
      lbist <= (i == 1);
      fal <= (i == 2);
      fes <= (i == 3) ? 8'h01 : ((i == 4) ? 8'h80 : 8'h00);
      fst <= (i == 5);
      @(posedge clk);
      {can2, lbist, fal, fst, fes} <= '0;
      #1 chk("chan", 32'(exp_tab[i]), 32'({ch24, rreq, chan}));
      @(posedge clk);
      #1 chk("channels after", 32'h0, {27'h0, chan});
    end
  endtask
  // one pulse of supply, stc, oscillator or pll fault, then the logged cause
  task automatic t_cause(input int k, input logic exp);
    logic [31:0] v;
    @(posedge clk);
    sup <= (k == 0);
    cpu_selftest_controller <= (k == 1);
    osc <= (k == 2);
    pll <= (k == 3);
    @(posedge clk);
    {sup, cpu_selftest_controller, osc, pll} <= '0;
    #1 chk("reset request", {31'h0, exp}, {31'h0, rreq});
    chk("collector quiet", 32'h0, {27'h0, chan});
    rd_reg(err_route_pkg::OFS_RESET_CAUSE, v);
    chk("reset cause", exp ? (32'h1 << (k > 2 ? 2 : k)) : 32'h0, v);
    wr_reg(err_route_pkg::OFS_RESET_CAUSE, 32'hf);
  endtask
  task automatic t_wd_nmi();
    logic [31:0] v;
    int n;
    rd_reg(err_route_pkg::OFS_WD_COUNT, v);
    chk("idle count", 32'hffffff, v);
    rd_reg(8'h40, v);
    chk("unmapped read", 32'h0, v);
    wr_reg(err_route_pkg::OFS_WD_TIMEOUT, 32'd40);
    wr_reg(err_route_pkg::OFS_WD_WINDOW, 32'd6);
    repeat (4) @(posedge clk);
    rd_reg(err_route_pkg::OFS_WD_COUNT, v);
    chk("count held while off", 32'd40, v);
    wr_reg(err_route_pkg::OFS_IRQ_MASK, 32'h1);
    wr_reg(err_route_pkg::OFS_WD_CTRL, 32'h3);
    wr_reg(err_route_pkg::OFS_WD_CTRL, 32'h0);
    wr_reg(err_route_pkg::OFS_WD_TIMEOUT, 32'd8);
    wr_reg(err_route_pkg::OFS_WD_WINDOW, 32'd20);
    rd_reg(err_route_pkg::OFS_WD_CTRL, v);
    chk("ctrl after disable", 32'h3, v);
    rd_reg(err_route_pkg::OFS_WD_TIMEOUT, v);
    chk("locked timeout", 32'd40, v);
    rd_reg(err_route_pkg::OFS_WD_WINDOW, v);
    chk("locked window", 32'd6, v);
    wr_reg(err_route_pkg::OFS_WD_SERVICE, 32'h1);
    // nmi channel stands one cycle only, starting one edge after the write is taken
    @(posedge clk);
    #1 chk("early service nmi", 32'h1, {31'h0, ch24});
    chk("irq raised", 32'h1, {31'h0, irq});
    chk("no reset in nmi mode", 32'h0, {31'h0, rreq});
    rd_reg(err_route_pkg::OFS_IRQ_STATUS, v);
    chk("violation status", 32'h1, v & 32'h1);
    chk("irq cleared", 32'h0, {31'h0, irq});
    // reads are two cycles apart, so the first hit lands at 6 or 5
    for (int i = 0; i < 30; i++)
    begin
      rd_reg(err_route_pkg::OFS_WD_COUNT, v);
      if (v <= 32'd6) break;
    end
    n = nmi_seen;
    wr_reg(err_route_pkg::OFS_WD_SERVICE, 32'h1);
    repeat (4) @(posedge clk);
    chk("in-window service", n, nmi_seen);
    repeat (56) @(posedge clk);
    chk("expiry nmi", n + 1, nmi_seen);
  endtask
  task automatic t_wd_reset();
    logic [31:0] v;
    int n;
    n = nmi_seen;
    do_reset();
    rd_reg(err_route_pkg::OFS_WD_CTRL, v);
    chk("ctrl after reset", 32'h0, v);
    wr_reg(err_route_pkg::OFS_WD_TIMEOUT, 32'd4);
    wr_reg(err_route_pkg::OFS_WD_CTRL, 32'h1);
    for (int i = 0; i < 12 && rreq !== 1'b1; i++)
    begin
      @(posedge clk);
      #1;
    end
    chk("watchdog reset", 32'h1, {31'h0, rreq});
    chk("no nmi in reset mode", n, nmi_seen);
    rd_reg(err_route_pkg::OFS_RESET_CAUSE, v);
    chk("watchdog cause", 32'h8, v);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // whole run is well under a thousand cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      bad_count++;
      complete_run();
    end
  end
  initial
  begin
    {rst_n, wr, rd, can2, lbist, fal, fst, sup, cpu_selftest_controller, osc, pll} = '0;
    fes = 8'h00;
    addr = 8'h00;
    wdata = 32'h0;
    do_reset();
    #1 chk("outputs after reset", 32'h0, {24'h0, ch24, rreq, irq, chan});
    t_routes();
    t_cause(0, 1'b1);
    t_cause(1, 1'b1);
    t_cause(2, 1'b0);
    t_cause(3, 1'b0);
    wr_reg(err_route_pkg::OFS_PLL_CTRL_ONE, 32'h1);
    t_cause(2, 1'b1);
    t_cause(3, 1'b1);
    t_wd_nmi();
    t_wd_reset();
    complete_run();
  end
endmodule
